//--- hw/gnl_pkg.sv
/*
  constants, field layouts and carrier types of the go/no-go limit checker.
  assumes one clock domain; all users refer to names as gnl_pkg::name.

  // How it works
  // - current high and low limits, written and read
  // - current limits checked in current or resistance mode
  // - low above high is never stored
  // - current under low limit raises no-good
  // - current over high limit raises no-good
  // - current inside window keeps its check quiet
  // - power limits held, used in power, resistance modes
  // - power under low limit raises no-good
  // - power over high limit raises no-good
  // - power inside window keeps its check quiet
  // - terminal voltage high and low limits held
  // - voltage under low limit raises no-good
  // - voltage over high limit raises no-good
  // - separate voltage pair for short test only
  // - short test voltage outside pair raises no-good
  // - no-good query reads one when flag set
*/
package gnl_pkg;

  // width of every limit and every measured value
  localparam int unsigned LIM_W     = 16;
  localparam int unsigned LIM_N     = 8;
  localparam int unsigned LIM_IDX_W = 3;

  // limit slots: even slots are highs, odd slots are lows
  localparam logic [2:0] LIM_CURR_HI  = 3'h0;
  localparam logic [2:0] LIM_CURR_LO  = 3'h1;
  localparam logic [2:0] LIM_POW_HI   = 3'h2;
  localparam logic [2:0] LIM_POW_LO   = 3'h3;
  localparam logic [2:0] LIM_VOLT_HI  = 3'h4;
  localparam logic [2:0] LIM_VOLT_LO  = 3'h5;
  localparam logic [2:0] LIM_SHORT_HI = 3'h6;
  localparam logic [2:0] LIM_SHORT_LO = 3'h7;

  // register byte offsets; limits fill 8'h00 to 8'h1c at four per slot
  localparam logic [2:0] LIM_REGION   = 3'h0;
  localparam logic [7:0] OFS_CTRL     = 8'h20;
  localparam logic [7:0] OFS_STATUS   = 8'h24;
  localparam logic [7:0] OFS_INT_STAT = 8'h28;
  localparam logic [7:0] OFS_INT_MASK = 8'h2c;

  // field positions
  localparam int unsigned CTRL_SHORT_BIT = 2;
  localparam int unsigned STAT_NG_BIT    = 0;
  localparam int unsigned IRQ_NOGOOD_RISE = 0;
  localparam int unsigned IRQ_REJECT     = 1;
  localparam int unsigned IRQ_W          = 2;

  // values after reset
  localparam logic [LIM_W-1:0] LIM_HI_RST   = 16'hffff;
  localparam logic [LIM_W-1:0] LIM_LO_RST   = 16'h0000;
  localparam logic [IRQ_W-1:0] INT_MASK_RST = 2'h0;

  // operating modes, numbered current, resistance, voltage, power
  typedef enum logic [1:0]
  {
    MODE_CURR,
    MODE_RES,
    MODE_VOLT,
    MODE_POW
  } gnl_mode_e;

  // one measurement sample from the front end
  typedef struct packed
  {
    logic             valid;
    logic [LIM_W-1:0] current;
    logic [LIM_W-1:0] power;
    logic [LIM_W-1:0] voltage;
  } gnl_meas_s;

endpackage

//--- hw/gnl_limit_store.sv
/*
  storage of the limit words with a registered read port and all words
  visible in parallel for the comparators.
  assumes the writer only presents writes that are already legal.
*/
module gnl_limit_store #(
  parameter int unsigned W  = 16,
  parameter int unsigned N  = 8,
  parameter int unsigned AW = 3
) (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                arst_n,
  // write port
  input  wire logic                wr_en,
  input  wire logic [AW-1:0]       wr_idx,
  input  wire logic [W-1:0]        wr_data,
  // read port, data one cycle after rd_en
  input  wire logic                rd_en,
  input  wire logic [AW-1:0]       rd_idx,
  output logic      [W-1:0]        rd_data,
  // every word at once
  output logic      [N-1:0][W-1:0] words
);

  logic [N-1:0][W-1:0] words_q;
  logic [W-1:0]        rd_q;

  assign words   = words_q;
  assign rd_data = rd_q;

  // highs reset open at all ones, lows at zero
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < N; i++)
        words_q[i] <= (i % 2 == 0) ? {W{1'b1}} : {W{1'b0}};
    end
    else if (wr_en)
      words_q[wr_idx] <= wr_data;
  end

  // registered read
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rd_q <= '0;
    else if (rd_en)
      rd_q <= words_q[rd_idx];
  end

endmodule

//--- hw/gnl_limit_checker.sv
/*
  go/no-go limit checker: limit registers, mode control, per-sample
  window comparison, no-good flag and interrupt.
  assumes a same-clock measurement front end and a register master that
  never drives both strobes at once.
*/
// Our own choices: strobed register access and the register addresses.
module gnl_limit_checker (
  // clock and reset
  input  wire logic              REF_CLK,
  input  wire logic              ARST_N,
  // register port
  input  wire logic [7:0]        BUS_ADDR,
  input  wire logic [31:0]       BUS_WDATA,
  input  wire logic              BUS_WR,
  input  wire logic              BUS_RD,
  output logic      [31:0]       BUS_RDATA,
  // measurement samples
  input  wire gnl_pkg::gnl_meas_s MEAS,
  // results
  output logic                   NO_GOOD,
  output logic                   IRQ
);

  localparam int unsigned LW = gnl_pkg::LIM_W;

  // true when v lies outside lo..hi
  function automatic logic outside(input logic [LW-1:0] v,
                                   input logic [LW-1:0] lo,
                                   input logic [LW-1:0] hi);
    outside = (v < lo) || (v > hi);
  endfunction

  logic [gnl_pkg::LIM_N-1:0][LW-1:0] lim_words;
  logic [LW-1:0]                     lim_rd;
  gnl_pkg::gnl_mode_e                mode_q;
  logic                              short_q;
  logic                              nogood_q;
  logic                              nogood_d;
  logic [gnl_pkg::IRQ_W-1:0]         int_stat_q;
  logic [gnl_pkg::IRQ_W-1:0]         int_mask_q;
  logic [gnl_pkg::IRQ_W-1:0]         int_set;
  logic [gnl_pkg::IRQ_W-1:0]         int_clr;
  logic                              rd_lim_q;
  logic [31:0]                       misc_q;

  // address decode
  wire                 lim_hit   = (BUS_ADDR[7:5] == gnl_pkg::LIM_REGION)
                                   && (BUS_ADDR[1:0] == 2'h0);
  wire [2:0]           lim_idx   = BUS_ADDR[4:2];
  wire                 lim_is_hi = ~lim_idx[0];
  wire [LW-1:0]        lim_wval  = BUS_WDATA[LW-1:0];
  wire [LW-1:0]        partner   = lim_words[lim_idx ^ 3'h1];
  wire                 ctrl_hit  = (BUS_ADDR == gnl_pkg::OFS_CTRL);
  wire                 stat_hit  = (BUS_ADDR == gnl_pkg::OFS_STATUS);
  wire                 istat_hit = (BUS_ADDR == gnl_pkg::OFS_INT_STAT);
  wire                 imask_hit = (BUS_ADDR == gnl_pkg::OFS_INT_MASK);

  // a limit write that would leave low above high is dropped
  wire lim_legal  = lim_is_hi ? (lim_wval >= partner)
                              : (lim_wval <= partner);
  wire lim_wr     = BUS_WR && lim_hit;
  wire lim_wr_ok  = lim_wr && lim_legal;
  wire lim_reject = lim_wr && !lim_legal;

  // limit storage
  gnl_limit_store #(
    .W  (LW),
    .N  (gnl_pkg::LIM_N),
    .AW (gnl_pkg::LIM_IDX_W)
  ) u_store (
    .clk     (REF_CLK),
    .arst_n  (ARST_N),
    .wr_en   (lim_wr_ok),
    .wr_idx  (lim_idx),
    .wr_data (lim_wval),
    .rd_en   (BUS_RD && lim_hit),
    .rd_idx  (lim_idx),
    .rd_data (lim_rd),
    .words   (lim_words)
  );

  // individual window checks against the current sample
  wire cur_bad   = outside(MEAS.current,
                           lim_words[gnl_pkg::LIM_CURR_LO],
                           lim_words[gnl_pkg::LIM_CURR_HI]);
  wire pow_bad   = outside(MEAS.power,
                           lim_words[gnl_pkg::LIM_POW_LO],
                           lim_words[gnl_pkg::LIM_POW_HI]);
  wire volt_bad  = outside(MEAS.voltage,
                           lim_words[gnl_pkg::LIM_VOLT_LO],
                           lim_words[gnl_pkg::LIM_VOLT_HI]);
  wire short_bad = outside(MEAS.voltage,
                           lim_words[gnl_pkg::LIM_SHORT_LO],
                           lim_words[gnl_pkg::LIM_SHORT_HI]);

  // which of the current and power checks apply in the present mode
  wire cur_on  = (mode_q == gnl_pkg::MODE_CURR)
                 || (mode_q == gnl_pkg::MODE_RES);
  wire pow_on  = (mode_q == gnl_pkg::MODE_POW)
                 || (mode_q == gnl_pkg::MODE_RES);

  // the short pair replaces the normal voltage pair during the test
  always_comb
  begin
    nogood_d = (cur_on && cur_bad) || (pow_on && pow_bad);
    if (short_q)
      nogood_d = nogood_d || short_bad;
    else
      nogood_d = nogood_d || volt_bad;
  end

  // no-good flag re-evaluated on each sample and held between them
  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      nogood_q <= 1'b0;
    else if (MEAS.valid)
      nogood_q <= nogood_d;
  end

  assign NO_GOOD = nogood_q;

  // mode and short test control
  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      mode_q  <= gnl_pkg::MODE_CURR;
      short_q <= 1'b0;
    end
    else if (BUS_WR && ctrl_hit)
    begin
      mode_q  <= gnl_pkg::gnl_mode_e'(BUS_WDATA[1:0]);
      short_q <= BUS_WDATA[gnl_pkg::CTRL_SHORT_BIT];
    end
  end

  // interrupt events: rising no-good and refused limit write
  assign int_set[gnl_pkg::IRQ_NOGOOD_RISE] =
    MEAS.valid && nogood_d && !nogood_q;
  assign int_set[gnl_pkg::IRQ_REJECT]  = lim_reject;
  assign int_clr = (BUS_WR && istat_hit) ? BUS_WDATA[gnl_pkg::IRQ_W-1:0]
                                         : '0;

  // sticky status, write one to clear, a set in the same cycle wins
  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      int_stat_q <= '0;
    else
      int_stat_q <= (int_stat_q & ~int_clr) | int_set;
  end

  // interrupt mask
  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      int_mask_q <= gnl_pkg::INT_MASK_RST;
    else if (BUS_WR && imask_hit)
      int_mask_q <= BUS_WDATA[gnl_pkg::IRQ_W-1:0];
  end

  assign IRQ = |(int_stat_q & int_mask_q);

  // read data of the registers that are not limits; unmapped reads zero
  wire [31:0] misc_rd =
    ctrl_hit  ? {29'h0, short_q, mode_q} :
    stat_hit  ? {31'h0, nogood_q} :
    istat_hit ? {{(32 - gnl_pkg::IRQ_W){1'b0}}, int_stat_q} :
    imask_hit ? {{(32 - gnl_pkg::IRQ_W){1'b0}}, int_mask_q} :
                32'h0;

  // capture read source and data one cycle after the strobe
  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      rd_lim_q <= 1'b0;
      misc_q   <= '0;
    end
    else if (BUS_RD)
    begin
      rd_lim_q <= lim_hit;
      misc_q   <= misc_rd;
    end
  end

  assign BUS_RDATA = rd_lim_q ? {{(32 - LW){1'b0}}, lim_rd}
                              : misc_q;

  // an accepted limit write is stored exactly
  property p_lim_store;
    @(posedge REF_CLK) disable iff (!ARST_N)
    lim_wr_ok |=> lim_words[$past(lim_idx)] == $past(lim_wval);
  endproperty
  a_lim_store: assert property (p_lim_store)
    else $error("accepted limit write not stored");

  // a refused write leaves every limit untouched
  property p_reject_hold;
    @(posedge REF_CLK) disable iff (!ARST_N)
    lim_reject |=> $stable(lim_words);
  endproperty
  a_reject_hold: assert property (p_reject_hold)
    else $error("illegal limit pair was stored");

  // every stored pair keeps low at or below high
  property p_pair_order;
    @(posedge REF_CLK) disable iff (!ARST_N)
    (lim_words[gnl_pkg::LIM_CURR_LO] <= lim_words[gnl_pkg::LIM_CURR_HI])
    && (lim_words[gnl_pkg::LIM_POW_LO] <= lim_words[gnl_pkg::LIM_POW_HI])
    && (lim_words[gnl_pkg::LIM_VOLT_LO] <= lim_words[gnl_pkg::LIM_VOLT_HI])
    && (lim_words[gnl_pkg::LIM_SHORT_LO]
        <= lim_words[gnl_pkg::LIM_SHORT_HI]);
  endproperty
  a_pair_order: assert property (p_pair_order)
    else $error("stored low limit above high limit");

  // current under its low limit in current or resistance mode
  property p_cur_low;
    @(posedge REF_CLK) disable iff (!ARST_N)
    MEAS.valid && cur_on
    && (MEAS.current < lim_words[gnl_pkg::LIM_CURR_LO]) |=> NO_GOOD;
  endproperty
  a_cur_low: assert property (p_cur_low)
    else $error("low current did not raise no-good");

  // current over its high limit in current or resistance mode
  property p_cur_high;
    @(posedge REF_CLK) disable iff (!ARST_N)
    MEAS.valid && cur_on
    && (MEAS.current > lim_words[gnl_pkg::LIM_CURR_HI]) |=> NO_GOOD;
  endproperty
  a_cur_high: assert property (p_cur_high)
    else $error("high current did not raise no-good");

  // in current mode with current and voltage inside, the flag stays low
  property p_cur_window;
    @(posedge REF_CLK) disable iff (!ARST_N)
    MEAS.valid && (mode_q == gnl_pkg::MODE_CURR) && !short_q
    && !cur_bad && !volt_bad |=> !NO_GOOD;
  endproperty
  a_cur_window: assert property (p_cur_window)
    else $error("no-good raised inside current window");

  // in cv the current limits are ignored
  property p_cv_ignores_current;
    @(posedge REF_CLK) disable iff (!ARST_N)
    MEAS.valid && (mode_q == gnl_pkg::MODE_VOLT) && !short_q && !volt_bad
    |=> !NO_GOOD;
  endproperty
  a_cv_ignores_current: assert property (p_cv_ignores_current)
    else $error("current or power checked in cv mode");

  // power outside its window in power mode raises the flag
  property p_pow_out;
    @(posedge REF_CLK) disable iff (!ARST_N)
    MEAS.valid && (mode_q == gnl_pkg::MODE_POW)
    && ((MEAS.power < lim_words[gnl_pkg::LIM_POW_LO])
        || (MEAS.power > lim_words[gnl_pkg::LIM_POW_HI])) |=> NO_GOOD;
  endproperty
  a_pow_out: assert property (p_pow_out)
    else $error("power outside window did not raise no-good");

  // power inside in power mode, with voltage inside, keeps it low
  property p_pow_window;
    @(posedge REF_CLK) disable iff (!ARST_N)
    MEAS.valid && (mode_q == gnl_pkg::MODE_POW) && !short_q
    && !pow_bad && !volt_bad |=> !NO_GOOD;
  endproperty
  a_pow_window: assert property (p_pow_window)
    else $error("no-good raised inside power window");

  // terminal voltage outside its normal pair outside the short test
  property p_volt_out;
    @(posedge REF_CLK) disable iff (!ARST_N)
    MEAS.valid && !short_q
    && ((MEAS.voltage < lim_words[gnl_pkg::LIM_VOLT_LO])
        || (MEAS.voltage > lim_words[gnl_pkg::LIM_VOLT_HI])) |=> NO_GOOD;
  endproperty
  a_volt_out: assert property (p_volt_out)
    else $error("voltage outside window did not raise no-good");

  // during the short test the short pair is used
  property p_short_out;
    @(posedge REF_CLK) disable iff (!ARST_N)
    MEAS.valid && short_q
    && ((MEAS.voltage < lim_words[gnl_pkg::LIM_SHORT_LO])
        || (MEAS.voltage > lim_words[gnl_pkg::LIM_SHORT_HI])) |=> NO_GOOD;
  endproperty
  a_short_out: assert property (p_short_out)
    else $error("short test voltage fault did not raise no-good");

  // without a sample the flag holds into the next cycle
  property p_flag_hold;
    @(posedge REF_CLK) disable iff (!ARST_N)
    !MEAS.valid |=> $stable(NO_GOOD);
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("no-good changed without a sample");

  // status read returns the flag as sampled with the strobe
  property p_flag_read;
    @(posedge REF_CLK) disable iff (!ARST_N)
    BUS_RD && stat_hit |=> BUS_RDATA == {31'h0, $past(NO_GOOD)};
  endproperty
  a_flag_read: assert property (p_flag_read)
    else $error("no-good status read wrong");

  // a limit read returns the stored word one cycle later
  property p_lim_read;
    @(posedge REF_CLK) disable iff (!ARST_N)
    BUS_RD && lim_hit
    |=> BUS_RDATA == {{(32 - LW){1'b0}}, $past(lim_words[lim_idx])};
  endproperty
  a_lim_read: assert property (p_lim_read)
    else $error("limit read back wrong");

  // refused write is reported in the status register
  property p_reject_flag;
    @(posedge REF_CLK) disable iff (!ARST_N)
    lim_reject |=> int_stat_q[gnl_pkg::IRQ_REJECT] ##1
    (int_stat_q[gnl_pkg::IRQ_REJECT] || $past(BUS_WR && istat_hit));
  endproperty
  a_reject_flag: assert property (p_reject_flag)
    else $error("refused limit write not flagged");

  // power over its high limit wherever the power pair applies
  property p_pow_high;
    @(posedge REF_CLK) disable iff (!ARST_N)
    MEAS.valid && pow_on
    && (MEAS.power > lim_words[gnl_pkg::LIM_POW_HI]) |=> NO_GOOD;
  endproperty
  a_pow_high: assert property (p_pow_high)
    else $error("high power did not raise no-good");

  // during the short test the normal voltage pair is left out
  property p_short_only;
    @(posedge REF_CLK) disable iff (!ARST_N)
    MEAS.valid && short_q && (mode_q == gnl_pkg::MODE_VOLT)
    && !short_bad |=> !NO_GOOD;
  endproperty
  a_short_only: assert property (p_short_only)
    else $error("normal voltage pair checked during short test");

  // a rising no-good event always lands in the sticky status
  property p_set_wins;
    @(posedge REF_CLK) disable iff (!ARST_N)
    int_set[gnl_pkg::IRQ_NOGOOD_RISE]
    |=> int_stat_q[gnl_pkg::IRQ_NOGOOD_RISE];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("rising no-good event lost");

endmodule

//--- testbench/gnl_host_model.sv
/*
  host model standing in for the remote controller: issues register
  writes and reads on the checker's plain register port.
  assumes each task call ends before the next one starts.
*/
module gnl_host_model (
  // clock
  input  wire logic        clk,
  // register port towards the checker
  output logic      [7:0]  addr,
  output logic      [31:0] wdata,
  output logic             wr,
  output logic             rd,
  input  wire logic [31:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus from time zero
  initial
  begin
    addr  = 8'h00;
    wdata = 32'h0000_0000;
    wr    = 1'b0;
    rd    = 1'b0;
  end

  // one-cycle write; released lines show the inverse of their last value
  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    addr  <= ~a;
    wdata <= ~d;
    #1;
  endtask

  // one-cycle read; data taken in the cycle after the strobe
  task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    addr <= ~a;
    #1;
    d = rdata;
  endtask
endmodule

//--- testbench/tb_top.sv
/*
  self-checking bench of the go/no-go limit checker: limit storage,
  refused pairs, per-mode window checks, status and interrupt.
  assumes the host model for register traffic; samples come from here.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // one measurement case: mode control, values and expected flag
  typedef struct
  {
    logic [2:0]  ctrl;
    logic [15:0] c;
    logic [15:0] p;
    logic [15:0] v;
    logic        ng;
  } gnl_tb_case_s;

  // design connections and bench state
  logic               REF_CLK;
  logic               ARST_N;
  logic [7:0]         BUS_ADDR;
  logic [31:0]        BUS_WDATA;
  logic               BUS_WR;
  logic               BUS_RD;
  logic [31:0]        BUS_RDATA;
  gnl_pkg::gnl_meas_s MEAS;
  logic               NO_GOOD;
  logic               IRQ;
  int                 num_errors;
  int                 check_count;
  logic [31:0]        rd_val;

  // limits: curr hi/lo, power hi/lo, volt hi/lo, short hi/lo
  logic [15:0]  lim_val [8] = '{16'h00c8, 16'h0064, 16'h0190, 16'h012c,
                               16'h0258, 16'h01f4, 16'h0050, 16'h0032};
  gnl_tb_case_s cases [18] = '{
    '{3'h0, 16'h0096, 16'h0000, 16'h0226, 1'b0},
    '{3'h0, 16'h0063, 16'h015e, 16'h0226, 1'b1},
    '{3'h0, 16'h0064, 16'h015e, 16'h0226, 1'b0},
    '{3'h0, 16'h00c9, 16'h015e, 16'h0226, 1'b1},
    '{3'h0, 16'h0096, 16'h015e, 16'h01f3, 1'b1},
    '{3'h0, 16'h0096, 16'h015e, 16'h0259, 1'b1},
    '{3'h1, 16'h0096, 16'h012b, 16'h0226, 1'b1},
    '{3'h1, 16'h0096, 16'h015e, 16'h0226, 1'b0},
    '{3'h1, 16'h00c9, 16'h015e, 16'h0226, 1'b1},
    '{3'h3, 16'h0000, 16'h0191, 16'h0226, 1'b1},
    '{3'h3, 16'h0000, 16'h0190, 16'h0226, 1'b0},
    '{3'h2, 16'h0000, 16'h0000, 16'h0226, 1'b0},
    '{3'h2, 16'h0000, 16'h0000, 16'h02bc, 1'b1},
    '{3'h6, 16'h0000, 16'h0000, 16'h0226, 1'b1},
    '{3'h6, 16'h0000, 16'h0000, 16'h003c, 1'b0},
    '{3'h6, 16'h0000, 16'h0000, 16'h0031, 1'b1},
    '{3'h4, 16'h0063, 16'h0000, 16'h003c, 1'b1},
    '{3'h0, 16'h0096, 16'h015e, 16'h0226, 1'b0}};

  gnl_limit_checker gnl_limit_checker_inst (
    .REF_CLK   (REF_CLK),
    .ARST_N    (ARST_N),
    .BUS_ADDR  (BUS_ADDR),
    .BUS_WDATA (BUS_WDATA),
    .BUS_WR    (BUS_WR),
    .BUS_RD    (BUS_RD),
    .BUS_RDATA (BUS_RDATA),
    .MEAS      (MEAS),
    .NO_GOOD   (NO_GOOD),
    .IRQ       (IRQ)
  );

  gnl_host_model gnl_host_model_inst (
    .clk   (REF_CLK),
    .addr  (BUS_ADDR),
    .wdata (BUS_WDATA),
    .wr    (BUS_WR),
    .rd    (BUS_RD),
    .rdata (BUS_RDATA)
  );

  // 125 MHz clock
  initial REF_CLK = 1'b0;
  always #4 REF_CLK = ~REF_CLK;

  // compare one value and count it
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // read a register and compare it
  task automatic rd_chk(input string what, input logic [7:0] a,
                        input logic [31:0] exp);
    gnl_host_model_inst.bus_read(a, rd_val);
    check(what, rd_val, exp);
  endtask

  // one-cycle sample; flag is settled just after the taking edge
  task automatic sample(input logic [15:0] c, p, v);
    @(posedge REF_CLK);
    MEAS <= '{1'b1, c, p, v};
    @(posedge REF_CLK);
    MEAS.valid <= 1'b0;
    #1;
  endtask

  // verdict and end of run
  task automatic wrap_up;
    if (num_errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // watchdog far beyond the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge REF_CLK);
    num_errors++;
    $display("MISMATCH watchdog expected done seen timeout");
    wrap_up();
  end

  // main sequence
  initial
  begin
    num_errors  = 0;
    check_count = 0;
    ARST_N      = 1'b0;
    MEAS        = '{1'b0, 16'h0000, 16'h0000, 16'h0000};
    repeat (8) @(posedge REF_CLK);
    ARST_N <= 1'b1;
    @(posedge REF_CLK);
    #1;
    check("no_good", {31'h0, NO_GOOD}, 32'h0000_0000);
    check("irq", {31'h0, IRQ}, 32'h0000_0000);
    // reset values, unmapped and read-only places
    for (int i = 0; i < 8; i++)
      rd_chk("lim_rst", 8'(4 * i), i[0] ? 32'h0 : 32'h0000_ffff);
    rd_chk("ctrl", gnl_pkg::OFS_CTRL, 32'h0000_0000);
    rd_chk("mask", gnl_pkg::OFS_INT_MASK, 32'h0000_0000);
    gnl_host_model_inst.bus_write(gnl_pkg::OFS_STATUS, 32'h0000_0001);
    rd_chk("status", gnl_pkg::OFS_STATUS, 32'h0000_0000);
    rd_chk("unmapped", 8'h30, 32'h0000_0000);
    rd_chk("misaligned", 8'h02, 32'h0000_0000);
    // lows before highs, so every written pair stays legal; junk upper half
    for (int i = 1; i < 8; i += 2)
      gnl_host_model_inst.bus_write(8'(4 * i), {16'habcd, lim_val[i]});
    for (int i = 0; i < 8; i += 2)
      gnl_host_model_inst.bus_write(8'(4 * i), {16'habcd, lim_val[i]});
    for (int i = 0; i < 8; i++)
      rd_chk("lim", 8'(4 * i), {16'h0, lim_val[i]});
    // inverted pairs refused, equal pair taken
    gnl_host_model_inst.bus_write(8'h04, 32'h0000_012c);
    rd_chk("curr_lo", 8'h04, 32'h0000_0064);
    gnl_host_model_inst.bus_write(8'h00, 32'h0000_0032);
    rd_chk("curr_hi", 8'h00, 32'h0000_00c8);
    gnl_host_model_inst.bus_write(8'h04, 32'h0000_00c8);
    rd_chk("curr_lo_eq", 8'h04, 32'h0000_00c8);
    gnl_host_model_inst.bus_write(8'h04, 32'h0000_0064);
    rd_chk("int_stat", gnl_pkg::OFS_INT_STAT, 32'h0000_0002);
    check("irq_masked", {31'h0, IRQ}, 32'h0000_0000);
    gnl_host_model_inst.bus_write(gnl_pkg::OFS_INT_MASK, 32'h0000_0003);
    check("irq_on", {31'h0, IRQ}, 32'h0000_0001);
    gnl_host_model_inst.bus_write(gnl_pkg::OFS_INT_STAT, 32'h0000_0002);
    check("irq_clr", {31'h0, IRQ}, 32'h0000_0000);
    rd_chk("int_stat_clr", gnl_pkg::OFS_INT_STAT, 32'h0000_0000);
    // per-mode window checks, each result seen on the pin and by query
    foreach (cases[k])
    begin
      gnl_host_model_inst.bus_write(gnl_pkg::OFS_CTRL, {29'h0, cases[k].ctrl});
      rd_chk("ctrl", gnl_pkg::OFS_CTRL, {29'h0, cases[k].ctrl});
      sample(cases[k].c, cases[k].p, cases[k].v);
      check("no_good", {31'h0, NO_GOOD}, {31'h0, cases[k].ng});
      rd_chk("status", gnl_pkg::OFS_STATUS, {31'h0, cases[k].ng});
    end
    // rising no-good events seen, then masked and cleared
    rd_chk("int_stat_nogood", gnl_pkg::OFS_INT_STAT, 32'h0000_0001);
    check("irq_nogood", {31'h0, IRQ}, 32'h0000_0001);
    gnl_host_model_inst.bus_write(gnl_pkg::OFS_INT_MASK, 32'h0000_0002);
    check("irq_mask", {31'h0, IRQ}, 32'h0000_0000);
    rd_chk("mask", gnl_pkg::OFS_INT_MASK, 32'h0000_0002);
    gnl_host_model_inst.bus_write(gnl_pkg::OFS_INT_STAT, 32'h0000_0001);
    rd_chk("int_stat_end", gnl_pkg::OFS_INT_STAT, 32'h0000_0000);
    wrap_up();
  end
endmodule
